// file: rtl/icoes_defines.svh
// Constants for the ingress credit and occupancy event selector.
// Assumes inclusion by bare name from the package and the top module.
`ifndef ICOES_DEFINES_SVH
`define ICOES_DEFINES_SVH
// Event codes
`define ICOES_EV_MISC 8'h60
`define ICOES_EV_OCC 8'h61
`define ICOES_EV_NET0 8'h43
`define ICOES_EV_NET1 8'h44
// Control word fields
`define ICOES_CODE_MSB 7
`define ICOES_CODE_LSB 0
`define ICOES_UMASK_MSB 15
`define ICOES_UMASK_LSB 8
// Sizes
`define ICOES_NUM_CNT 4
`define ICOES_OCC_W 8
`define ICOES_INC_W 11
`define ICOES_CLS_W 7
// Register byte offsets
`define ICOES_OFF_SEL 8'h00
`define ICOES_OFF_MODE 8'h10
`define ICOES_OFF_INC 8'h20
// Reset values
`define ICOES_CTL_RST 16'h0000
`define ICOES_MODE_RST 1'b0
`endif

// file: rtl/icoes_pkg.sv
// Types and shared helpers of the event selector.
// Assumes the defines header sits beside it.
package icoes_pkg;
`include "icoes_defines.svh"
  typedef logic [`ICOES_INC_W-1:0] icoes_inc_t;
  typedef logic [`ICOES_OCC_W-1:0] icoes_occ_t;
  typedef logic [`ICOES_CLS_W-1:0] icoes_cls_t;
  typedef struct packed {
    logic [7:0] umask;
    logic [7:0] code;
  } icoes_ctl_t;
  typedef struct packed {
    logic       fifo_any;
    logic       path_any;
    logic       arb_block;
    icoes_occ_t shared_cred;
    icoes_occ_t fifo_n;
    icoes_occ_t path_n;
    icoes_occ_t tx_queue;
    icoes_occ_t comp_cred;
    icoes_occ_t pend_total;
    icoes_occ_t pend_fifo;
    icoes_cls_t net0_ne;
    icoes_cls_t net1_ne;
    icoes_cls_t net1_alloc;
  } icoes_cond_t;
  typedef enum logic [0:0] {
    ICOES_BUS_IDLE = 1'b0,
    ICOES_BUS_WAIT = 1'b1
  } icoes_bus_t;
  function automatic icoes_inc_t icoes_pick(input icoes_occ_t v, input logic en);
    return en ? icoes_inc_t'(v) : icoes_inc_t'(0);
  endfunction
  function automatic icoes_inc_t icoes_any(input icoes_cls_t c, input icoes_cls_t m);
    return icoes_inc_t'(|(c & m));
  endfunction
endpackage

// file: rtl/icoes_sel_if.sv
// Selection carrier between the top and one event selector.
// Assumes the package is compiled first.
`timescale 1ns/1ps
`default_nettype none
interface icoes_sel_if;
  import icoes_pkg::*;
  icoes_ctl_t ctl;
  logic       net1_alloc;
  icoes_inc_t inc;
  modport sel (input ctl, input net1_alloc, output inc);
  modport cfg (output ctl, output net1_alloc, input inc);
endinterface
`default_nettype wire

// file: rtl/icoes_ctl_file.sv
// Control words of the counters and the mode bit.
// Assumes writes come one at a time from the bus slave.
`timescale 1ns/1ps
`default_nettype none
module icoes_ctl_file (
  input  wire logic                                   hclk,
  input  wire logic                                   hresetn,
  input  wire logic                                   ce,
  input  wire logic                                   ctl_we,
  input  wire logic [1:0]                             ctl_widx,
  input  wire icoes_pkg::icoes_ctl_t                  ctl_wdata,
  input  wire logic                                   mode_we,
  input  wire logic                                   mode_wdata,
  output var  icoes_pkg::icoes_ctl_t [`ICOES_NUM_CNT-1:0] ctl,
  output var  logic                                   mode
);
  import icoes_pkg::*;
  icoes_ctl_t [`ICOES_NUM_CNT-1:0] next_ctl;
  logic                            next_mode;

  always_comb
  begin
    next_ctl = ctl;
    next_mode = mode;
    if (ctl_we)
      next_ctl[ctl_widx] = ctl_wdata;
    if (mode_we)
      next_mode = mode_wdata;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctl <= {`ICOES_NUM_CNT{`ICOES_CTL_RST}};
      mode <= `ICOES_MODE_RST;
    end
    else if (ce)
    begin
      ctl <= next_ctl;
      mode <= next_mode;
    end
  end
endmodule
`default_nettype wire

// file: rtl/icoes_select.sv
// One event selector: code and mask turn conditions into an increment.
// Assumes conditions arrive already registered.
`timescale 1ns/1ps
`default_nettype none
module icoes_select (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  ce,
  input  wire icoes_pkg::icoes_cond_t cond,
  icoes_sel_if.sel                   sif
);
  import icoes_pkg::*;
  icoes_inc_t next_inc;
  icoes_cls_t um;

  always_comb
  begin
    um = sif.ctl.umask[`ICOES_CLS_W-1:0];
    next_inc = '0;
    case (sif.ctl.code)
      `ICOES_EV_MISC:
        next_inc = icoes_any({4'h0, cond.arb_block, cond.path_any, cond.fifo_any}, um);
      `ICOES_EV_OCC:
        next_inc = icoes_pick(cond.shared_cred, um[0])
                 + icoes_pick(cond.fifo_n, um[1])
                 + icoes_pick(cond.path_n, um[2])
                 + icoes_pick(cond.tx_queue, um[3])
                 + icoes_pick(cond.comp_cred, um[4])
                 + icoes_pick(cond.pend_total, um[5])
                 + icoes_pick(cond.pend_fifo, um[6]);
      `ICOES_EV_NET0:
        next_inc = icoes_any(cond.net0_ne, um);
      `ICOES_EV_NET1:
        next_inc = icoes_any(sif.net1_alloc ? cond.net1_alloc : cond.net1_ne, um);
      default:
        next_inc = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sif.inc <= '0;
    else if (ce)
      sif.inc <= next_inc;
  end
endmodule
`default_nettype wire

// file: rtl/icoes_top.sv
// Ingress credit and occupancy event selector with AHB-Lite registers.
// Assumes condition inputs synchronous to hclk, one counter per output.
// Notes on behaviour
// - Misc credit code with mask bit 0 counts cycles with a flit in the crossing FIFO.
// - Misc credit code with mask bit 1 counts cycles with a flit anywhere in the crossing path.
// - Misc credit code with mask bit 2 counts cycles a data-ring response waits for completion credits.
// - Occupancy code with mask bit 0 adds shared adaptive credits in use every cycle.
// - Occupancy code mask bit 1 adds flits in the crossing FIFO, bit 2 flits in pipe plus FIFO.
// - Occupancy code mask bit 3 adds link transmit queue credits in use.
// - Occupancy code mask bit 4 adds completion FIFO credits in use.
// - Occupancy code mask bit 5 adds pump-one-pending messages in table and FIFO.
// - Occupancy code mask bit 6 adds pump-one-pending messages in the FIFO only.
// - Network zero code counts cycles its ingress queue holds a selected class.
// - Mask bits 0 to 6 pick the seven message classes for the queue events.
// - Network one code applies the class mask to the network one queue, mode picks meaning.
// - Each counter has its own code and mask; the one mode bit is shared, so it picks the network one meaning for every counter.
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`include "icoes_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module icoes_top (
  input  wire logic                                   hclk,
  input  wire logic                                   hresetn,
  input  wire logic                                   ce,
  input  wire logic                                   hsel,
  input  wire logic [31:0]                            haddr,
  input  wire logic [1:0]                             htrans,
  input  wire logic                                   hwrite,
  input  wire logic [2:0]                             hsize,
  input  wire logic [31:0]                            hwdata,
  input  wire logic                                   hready,
  output logic                                        hreadyout,
  output logic                                        hresp,
  output logic [31:0]                                 hrdata,
  input  wire logic                                   fifo_flit_present,
  input  wire logic                                   path_flit_present,
  input  wire logic                                   completion_credit_arb_block,
  input  wire icoes_pkg::icoes_occ_t                  shared_credits_in_use,
  input  wire icoes_pkg::icoes_occ_t                  fifo_flit_count,
  input  wire icoes_pkg::icoes_occ_t                  path_flit_count,
  input  wire icoes_pkg::icoes_occ_t                  link_tx_queue_credits,
  input  wire icoes_pkg::icoes_occ_t                  completion_fifo_credits,
  input  wire icoes_pkg::icoes_occ_t                  pump_one_pending_total,
  input  wire icoes_pkg::icoes_occ_t                  pump_one_pending_fifo_only,
  input  wire icoes_pkg::icoes_cls_t                  net_zero_class_ne,
  input  wire icoes_pkg::icoes_cls_t                  net_one_class_ne,
  input  wire icoes_pkg::icoes_cls_t                  net_one_class_alloc,
  output logic [`ICOES_NUM_CNT-1:0][`ICOES_INC_W-1:0] inc
);
  import icoes_pkg::*;

  function automatic logic in_bank(input logic [5:0] a, input logic [7:0] off);
    return a[5:2] == off[7:4];
  endfunction

  icoes_bus_t                      st;
  icoes_bus_t                      next_st;
  logic [5:0]                      addr_q;
  logic [5:0]                      next_addr;
  logic                            wr_q;
  logic                            next_wr;
  logic                            hit_q;
  logic                            next_hit;
  logic                            next_ready;
  logic [31:0]                     next_rdata;
  logic [31:0]                     rd_word;
  logic                            ctl_we;
  logic                            mode_we;
  icoes_ctl_t [`ICOES_NUM_CNT-1:0] ctl_q;
  logic                            mode_q;
  icoes_cond_t                     cond_q;
  icoes_cond_t                     next_cond;

  // Bus slave: one wait state, then OKAY
  always_comb
  begin
    next_st = st;
    next_addr = addr_q;
    next_wr = wr_q;
    next_hit = hit_q;
    next_ready = hreadyout;
    next_rdata = hrdata;
    ctl_we = 1'b0;
    mode_we = 1'b0;
    case (st)
      ICOES_BUS_IDLE:
      begin
        next_ready = 1'b1;
        if (hsel && htrans[1] && hready)
        begin
          next_st = ICOES_BUS_WAIT;
          next_addr = haddr[7:2];
          next_wr = hwrite;
          next_hit = haddr[31:8] == 24'h000000;
          next_ready = 1'b0;
        end
      end
      ICOES_BUS_WAIT:
      begin
        next_st = ICOES_BUS_IDLE;
        next_ready = 1'b1;
        if (wr_q)
        begin
          ctl_we = hit_q && in_bank(addr_q, `ICOES_OFF_SEL);
          mode_we = hit_q && (addr_q == 6'(`ICOES_OFF_MODE >> 2));
        end
        else
        begin
          next_rdata = rd_word;
        end
      end
      default:
      begin
        next_st = ICOES_BUS_IDLE;
        next_ready = 1'b1;
      end
    endcase
  end

  // Read mux, unmapped reads give zero
  always_comb
  begin
    rd_word = 32'h00000000;
    if (hit_q && in_bank(addr_q, `ICOES_OFF_SEL))
      rd_word = {16'h0000, ctl_q[addr_q[1:0]]};
    else if (hit_q && (addr_q == 6'(`ICOES_OFF_MODE >> 2)))
      rd_word = {31'h00000000, mode_q};
    else if (hit_q && in_bank(addr_q, `ICOES_OFF_INC))
      rd_word = {{(32 - `ICOES_INC_W){1'b0}}, inc[addr_q[1:0]]};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= ICOES_BUS_IDLE;
      addr_q <= 6'h00;
      wr_q <= 1'b0;
      hit_q <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end
    else if (ce)
    begin
      st <= next_st;
      addr_q <= next_addr;
      wr_q <= next_wr;
      hit_q <= next_hit;
      hreadyout <= next_ready;
      hresp <= 1'b0;
      hrdata <= next_rdata;
    end
  end

  // Control words, code low byte and mask high byte
  icoes_ctl_file u_ctl (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .ce         (ce),
    .ctl_we     (ctl_we),
    .ctl_widx   (addr_q[1:0]),
    .ctl_wdata  (hwdata[15:0]),
    .mode_we    (mode_we),
    .mode_wdata (hwdata[0]),
    .ctl        (ctl_q),
    .mode       (mode_q)
  );

  // Condition snapshot shared by all selectors
  always_comb
  begin
    next_cond.fifo_any = fifo_flit_present;
    next_cond.path_any = path_flit_present;
    next_cond.arb_block = completion_credit_arb_block;
    next_cond.shared_cred = shared_credits_in_use;
    next_cond.fifo_n = fifo_flit_count;
    next_cond.path_n = path_flit_count;
    next_cond.tx_queue = link_tx_queue_credits;
    next_cond.comp_cred = completion_fifo_credits;
    next_cond.pend_total = pump_one_pending_total;
    next_cond.pend_fifo = pump_one_pending_fifo_only;
    next_cond.net0_ne = net_zero_class_ne;
    next_cond.net1_ne = net_one_class_ne;
    next_cond.net1_alloc = net_one_class_alloc;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cond_q <= '0;
    else if (ce)
      cond_q <= next_cond;
  end

  // One independent selector per counter
  for (genvar gi = 0; gi < `ICOES_NUM_CNT; gi++)
  begin : g_cnt
    icoes_sel_if sif ();
    assign sif.ctl = ctl_q[gi];
    assign sif.net1_alloc = mode_q;
    assign inc[gi] = sif.inc;
    icoes_select u_sel (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ce      (ce),
      .cond    (cond_q),
      .sif     (sif.sel)
    );
  end

  // Checks
  property p_sel(logic [7:0] code, logic [7:0] um, logic [`ICOES_INC_W-1:0] want);
    @(posedge hclk) disable iff (!hresetn)
      (ce && ctl_q[0].code == code && ctl_q[0].umask == um) |=> (inc[0] == $past(want));
  endproperty

  a_misc_fifo_flag: assert property (p_sel(8'h60, 8'h01, icoes_inc_t'(cond_q.fifo_any)))
    else $error("fifo flag increment wrong");
  a_misc_path_flag: assert property (p_sel(8'h60, 8'h02, icoes_inc_t'(cond_q.path_any)))
    else $error("path flag increment wrong");
  a_misc_arb_block: assert property (p_sel(8'h60, 8'h04, icoes_inc_t'(cond_q.arb_block)))
    else $error("arbitration block increment wrong");
  a_occ_shared_cred: assert property (p_sel(8'h61, 8'h01, icoes_inc_t'(cond_q.shared_cred)))
    else $error("shared credit occupancy wrong");
  a_occ_fifo_path: assert property (p_sel(8'h61, 8'h06,
      icoes_inc_t'(cond_q.fifo_n) + icoes_inc_t'(cond_q.path_n)))
    else $error("crossing occupancy sum wrong");
  a_occ_tx_queue: assert property (p_sel(8'h61, 8'h08, icoes_inc_t'(cond_q.tx_queue)))
    else $error("transmit queue occupancy wrong");
  a_occ_comp_cred: assert property (p_sel(8'h61, 8'h10, icoes_inc_t'(cond_q.comp_cred)))
    else $error("completion credit occupancy wrong");
  a_occ_pend_sum: assert property (p_sel(8'h61, 8'h60,
      icoes_inc_t'(cond_q.pend_total) + icoes_inc_t'(cond_q.pend_fifo)))
    else $error("pending occupancy sum wrong");

  a_net0_any_class: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && ctl_q[0].code == 8'h43) |=>
      (inc[0] == icoes_inc_t'(|($past(cond_q.net0_ne) & $past(ctl_q[0].umask[6:0])))))
    else $error("network zero not-empty wrong");
  a_net1_mode_pick: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && ctl_q[1].code == 8'h44) |=>
      (inc[1] == icoes_inc_t'(|(($past(mode_q) ? $past(cond_q.net1_alloc)
                                               : $past(cond_q.net1_ne))
                                & $past(ctl_q[1].umask[6:0])))))
    else $error("network one selection wrong");
  a_ctl_write_field: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && ctl_we && addr_q[1:0] == 2'h2) |=> (ctl_q[2] == $past(hwdata[15:0])))
    else $error("control word not stored");
  a_bus_one_wait: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && st == ICOES_BUS_IDLE && hsel && htrans[1] && hready) |=>
      !hreadyout ##1 (hreadyout || !$past(ce)))
    else $error("wait state not one cycle");
  a_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn) !hresp)
    else $error("error response seen");

  // Bus and clock-enable checks
  a_mode_write_land: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && mode_we) |=> (mode_q == $past(hwdata[0])))
    else $error("mode bit not stored");
  a_mode_read_data: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && st == ICOES_BUS_WAIT && !wr_q && hit_q && addr_q == 6'h04) |=>
      (hrdata == {31'h00000000, $past(mode_q)}))
    else $error("mode bit read wrong");
  a_idle_ready_high: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && st == ICOES_BUS_IDLE && !(hsel && htrans[1] && hready)) |=>
      hreadyout)
    else $error("ready low without request");
  a_rdata_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && st == ICOES_BUS_IDLE) |=>
      $stable(hrdata))
    else $error("read data changed while idle");
  a_ce_freeze: assert property (@(posedge hclk) disable iff (!hresetn)
      (!ce) |=>
      ($stable(inc) && $stable(st)))
    else $error("state moved with enable low");

  // Reference sum for the occupancy event
  function automatic icoes_inc_t occ_ref(input icoes_cond_t c, input logic [7:0] m);
    icoes_inc_t s;
    s = '0;
    if (m[0])
      s = s + icoes_inc_t'(c.shared_cred);
    if (m[1])
      s = s + icoes_inc_t'(c.fifo_n);
    if (m[2])
      s = s + icoes_inc_t'(c.path_n);
    if (m[3])
      s = s + icoes_inc_t'(c.tx_queue);
    if (m[4])
      s = s + icoes_inc_t'(c.comp_cred);
    if (m[5])
      s = s + icoes_inc_t'(c.pend_total);
    if (m[6])
      s = s + icoes_inc_t'(c.pend_fifo);
    return s;
  endfunction

  // Every counter checked on its own selection
  for (genvar gc = 0; gc < `ICOES_NUM_CNT; gc++)
  begin : g_chk
    a_misc_any_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && ctl_q[gc].code == `ICOES_EV_MISC) |=>
        (inc[gc] == icoes_inc_t'(|($past(ctl_q[gc].umask[2:0])
            & $past({cond_q.arb_block, cond_q.path_any, cond_q.fifo_any})))))
      else $error("misc flag increment wrong");

    a_occ_sel_sum: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && ctl_q[gc].code == `ICOES_EV_OCC) |=>
        (inc[gc] == $past(occ_ref(cond_q, ctl_q[gc].umask))))
      else $error("occupancy sum wrong");

    a_net0_per_cnt: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && ctl_q[gc].code == `ICOES_EV_NET0) |=>
        (inc[gc] == icoes_inc_t'(|($past(cond_q.net0_ne) & $past(ctl_q[gc].umask[6:0])))))
      else $error("network zero counter wrong");

    a_net1_per_cnt: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && ctl_q[gc].code == `ICOES_EV_NET1) |=>
        (inc[gc] == icoes_inc_t'(|(($past(mode_q) ? $past(cond_q.net1_alloc)
                                                  : $past(cond_q.net1_ne))
                                   & $past(ctl_q[gc].umask[6:0])))))
      else $error("network one counter wrong");

    a_other_code_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && !(ctl_q[gc].code inside {`ICOES_EV_MISC, `ICOES_EV_OCC,
                                        `ICOES_EV_NET0, `ICOES_EV_NET1})) |=>
        (inc[gc] == '0))
      else $error("unknown code not zero");
  end

  c_occ_multi: cover property (@(posedge hclk) disable iff (!hresetn)
      ctl_q[0].code == 8'h61 && ctl_q[0].umask[1] && ctl_q[0].umask[2] && inc[0] != 0);
  c_net1_alloc: cover property (@(posedge hclk) disable iff (!hresetn)
      mode_q && ctl_q[1].code == 8'h44 && inc[1] != 0);
  c_read_inc: cover property (@(posedge hclk) disable iff (!hresetn)
      st == ICOES_BUS_WAIT && !wr_q && in_bank(addr_q, `ICOES_OFF_INC));
  c_two_counters: cover property (@(posedge hclk) disable iff (!hresetn)
      ctl_q[0].code == 8'h43 && ctl_q[1].code == 8'h44 && inc[0] != 0 && inc[1] != 0);
  c_misc_flags: cover property (@(posedge hclk) disable iff (!hresetn)
      ctl_q[0].code == 8'h60 && inc[0] != 0);
endmodule
`default_nettype wire

// file: testbench/icoes_perf_model.sv
// Model of the generic counters that accumulate the selector's increments.
// Assumes increments are registered levels on hclk, one per counter.
`timescale 1ns/1ps
`default_nettype none
`include "icoes_defines.svh"
module icoes_perf_model (
  input  wire logic                                        hclk,
  input  wire logic                                        hresetn,
  input  wire logic                                        clr,
  input  wire logic [`ICOES_NUM_CNT-1:0][`ICOES_INC_W-1:0] inc,
  output var  logic [`ICOES_NUM_CNT-1:0][31:0]             total
);
  logic [`ICOES_NUM_CNT-1:0][31:0] next_total;
  // Each counter adds its own increment every cycle that clr is low
  always_comb
  begin
    for (int i = 0; i < `ICOES_NUM_CNT; i++)
    begin
      next_total[i] = clr ? 32'h0000_0000 : total[i] + 32'(inc[i]);
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      total <= '0;
    end
    else
    begin
      total <= next_total;
    end
  end
endmodule
`default_nettype wire

// file: testbench/test_ingress_credit_occupancy_event_select.sv
// Self-checking bench for the event selector, registers over AHB-Lite.
// Assumes the design package, interface and counter model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "icoes_defines.svh"
module test_ingress_credit_occupancy_event_select;
  import icoes_pkg::*;
  logic hclk, hresetn, clr, hsel, hwrite, fifo_any, path_any, arb_blk;
  logic hreadyout, hresp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  icoes_occ_t shared_c, fifo_c, path_c, txq_c, comp_c, ptot_c, pfifo_c;
  icoes_cls_t n0_ne, n1_ne, n1_al;
  logic [`ICOES_NUM_CNT-1:0][`ICOES_INC_W-1:0] inc;
  logic [`ICOES_NUM_CNT-1:0][31:0] total;
  logic [7:0] codes [4];
  int err_count, checks;
  icoes_top u_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fifo_flit_present(fifo_any),
    .path_flit_present(path_any), .completion_credit_arb_block(arb_blk),
    .shared_credits_in_use(shared_c), .fifo_flit_count(fifo_c), .path_flit_count(path_c),
    .link_tx_queue_credits(txq_c), .completion_fifo_credits(comp_c),
    .pump_one_pending_total(ptot_c), .pump_one_pending_fifo_only(pfifo_c),
    .net_zero_class_ne(n0_ne), .net_one_class_ne(n1_ne), .net_one_class_alloc(n1_al),
    .inc(inc));
  icoes_perf_model u_cnt (.hclk(hclk), .hresetn(hresetn), .clr(clr), .inc(inc),
    .total(total));
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask
  task automatic chk_inc(input icoes_inc_t got, input icoes_inc_t exp, input int i);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL %0t inc %0d got %0h exp %0h", $time, i, got, exp);
    end
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 20)
    begin
      @(posedge hclk);
      n++;
    end
    chk_word(32'(n), 32'(n % 20), "bus wait");
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk_word({31'h0, hresp}, 32'h0, "hresp");
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk_word(rd, exp, "read");
  endtask
  function automatic icoes_inc_t exp_inc(input logic [7:0] code, input logic [7:0] m,
                                         input logic md);
    icoes_inc_t s;
    icoes_occ_t occ [7];
    s = '0;
    occ = '{shared_c, fifo_c, path_c, txq_c, comp_c, ptot_c, pfifo_c};
    case (code)
      `ICOES_EV_MISC: s = icoes_inc_t'(|(m[2:0] & {arb_blk, path_any, fifo_any}));
      `ICOES_EV_OCC:
        for (int k = 0; k < 7; k++)
        begin
          s += m[k] ? icoes_inc_t'(occ[k]) : icoes_inc_t'(0);
        end
      `ICOES_EV_NET0: s = icoes_inc_t'(|(m[6:0] & n0_ne));
      `ICOES_EV_NET1: s = icoes_inc_t'(|(m[6:0] & (md ? n1_al : n1_ne)));
      default: s = '0;
    endcase
    return s;
  endfunction
  task automatic set_cond(input logic v);
    {fifo_any, path_any, arb_blk} <= 3'h5 ^ {3{v}};
    {shared_c, fifo_c, path_c} <= 24'h03_05_09 ^ {24{v}};
    {txq_c, comp_c, ptot_c, pfifo_c} <= 32'h11_21_41_81 ^ {32{v}};
    {n0_ne, n1_ne, n1_al} <= 21'h0AA8B4 ^ {21{v}};
  endtask
  // Each counter watches a different code; masks walk every bit, then groups
  task automatic sweep(input logic md);
    logic [7:0] m;
    ahb(1'b1, 32'h10, {31'h0, md});
    for (int b = 0; b < 10; b++)
    begin
      m = (b < 8) ? 8'(1 << b) : ((b == 8) ? 8'h7F : 8'hFF);
      for (int i = 0; i < 4; i++)
      begin
        ahb(1'b1, 32'(4 * i), {16'h0, m, codes[(i + md) % 4]});
      end
      repeat (3) @(posedge hclk);
      #1;
      for (int i = 0; i < 4; i++)
      begin
        chk_inc(inc[i], exp_inc(codes[(i + md) % 4], m, md), i);
      end
      rd_chk(32'h24, 32'(exp_inc(codes[(1 + md) % 4], m, md)));
    end
    $display("test sweep mode %0d done", md);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial
  begin
    #(40 * 6000);
    err_count++;
    tally_and_finish();
  end
  initial
  begin
    codes = '{`ICOES_EV_MISC, `ICOES_EV_OCC, `ICOES_EV_NET0, `ICOES_EV_NET1};
    {hresetn, clr, hsel, hwrite, htrans, haddr, hwdata} = '0;
    err_count = 0;
    checks = 0;
    set_cond(1'b0);
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      rd_chk(32'(4 * i), 32'h0);
      rd_chk(32'h20 + 32'(4 * i), 32'h0);
    end
    rd_chk(32'h10, 32'h0);
    $display("test reset done");
    ahb(1'b1, 32'h0, 32'hFFFF_A5C3);
    rd_chk(32'h0, 32'h0000_A5C3);
    ahb(1'b1, 32'h10, 32'hFFFF_FFFF);
    rd_chk(32'h10, 32'h1);
    ahb(1'b1, 32'h40, 32'hFFFF_FFFF);
    rd_chk(32'h40, 32'h0);
    rd_chk(32'h100, 32'h0);
    ahb(1'b1, 32'h20, 32'hFFFF_FFFF);
    rd_chk(32'h20, 32'h0);
    $display("test registers done");
    sweep(1'b0);
    set_cond(1'b1);
    sweep(1'b1);
    @(posedge hclk);
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
    repeat (10) @(posedge hclk);
    #1;
    for (int i = 0; i < 4; i++)
    begin
      chk_word(total[i], 32'(exp_inc(codes[(i + 1) % 4], 8'hFF, 1'b1)) * 10, "total");
    end
    $display("test accumulate done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
